/* File: rtl/cppg_interp.sv */
// Purpose: Linear interpolation and extrapolation between two points
// Assumes: Operands fit 32 bits signed
// Notes: A zero span returns the first point
`timescale 1ns/100ps
`default_nettype none
module cppg_interp (
    cppg_interp_if.calc bus
);
    logic signed [63:0] prod;

    always_comb begin
        prod = 64'(bus.b - bus.a) * 64'(bus.num);
        if (bus.den == 32'sh0) begin
            bus.result = bus.a;
        end else begin
            bus.result = bus.a + 32'(prod / 64'(bus.den));
        end
    end
endmodule
`default_nettype wire

/* File: rtl/cppg_top.sv */
// Purpose: Cam feed position from cycle position and stored cam profile
// Assumes: CYCLE_POS from same clock domain, within 0 to cycle length
// Notes: Engage command is a pin and is synchronised
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module cppg_top
    import cppg_pkg::*;
#(
    parameter int CAMS = NUM_CAMS,
    parameter int CRD_N = MAX_CRD
)(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CAM_ENGAGE_COMMAND,
    input wire logic [31:0] CYCLE_POS,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    output logic signed [31:0] FEED_POS,
    output logic signed [31:0] STD_POS,
    output logic CAM_ACTIVE
);
    if (CAMS < 1 || CAMS > NUM_CAMS || CRD_N < MIN_CRD || CRD_N > MAX_CRD) begin : g_bad
        $error("cppg_top: unsupported parameter values");
    end

    logic signed [31:0] ratio_mem [CAMS*MAX_RES];
    logic signed [31:0] x_mem [CAMS*CRD_N];
    logic signed [31:0] y_mem [CAMS*CRD_N];
    cppg_mode_e mode_cfg, act_mode;
    logic [1:0] res_sel;
    logic [3:0] cam_cfg, act_cam;
    logic signed [31:0] stroke_cfg, act_stroke;
    logic [10:0] start_cfg, ncrd_cfg;
    logic [31:0] cyc_len;
    logic [2:0] mem_prof;
    logic [10:0] mem_idx;
    logic eng_s1, eng_s2, eng_s3, rise;
    logic [10:0] seg, next_seg;
    int j_prev;
    logic [31:0] p_prev;

    int res, j, n, cbase;
    logic [63:0] scaled, step, frac;
    logic signed [31:0] p, ra, rb, r_last, xa, xb, ya, yb;
    logic signed [31:0] adv, next_std, next_feed;
    logic wrap_fwd, wrap_bwd;

    cppg_interp_if seg_if ();
    cppg_interp_if zero_if ();
    cppg_interp_if full_if ();
    cppg_interp u_seg (.bus(seg_if));
    cppg_interp u_zero (.bus(zero_if));
    cppg_interp u_full (.bus(full_if));

    function automatic int res_of(input logic [1:0] sel);
        return RES_BASE << sel;
    endfunction
    function automatic logic signed [31:0] sat(input logic signed [31:0] v, input logic signed [31:0] lim);
        return (v > lim) ? lim : ((v < -lim) ? -lim : v);
    endfunction

    // Point zero is always 0 percent; stored data hold points 1 to res
    function automatic logic signed [31:0] ratio_at(input logic [3:0] cam, input int k, input int r);
        logic signed [63:0] lin;
        lin = 64'(k) * 64'(RATIO_FULL) / 64'(r);
        if (cam == 4'h0) begin
            return 32'(lin);
        end
        if (k == 0) begin
            return 32'sh0;
        end
        return ratio_mem[(int'(cam) - 1) * MAX_RES + k - 1];
    endfunction

    // Engage pin synchroniser and edge
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            eng_s1 <= 1'b0;
            eng_s2 <= 1'b0;
            eng_s3 <= 1'b0;
        end else begin
            eng_s1 <= CAM_ENGAGE_COMMAND;
            eng_s2 <= eng_s1;
            eng_s3 <= eng_s2;
        end
    end
    assign rise = eng_s2 & ~eng_s3;

    // Register writes
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            mode_cfg <= CPPG_RATIO;
            res_sel <= 2'h0;
            cam_cfg <= 4'h0;
            stroke_cfg <= 32'sh0;
            start_cfg <= START_RST;
            ncrd_cfg <= NCRD_RST;
            cyc_len <= CYCLEN_RST;
            mem_prof <= 3'h0;
            mem_idx <= 11'h000;
        end else if (REG_WR) begin
            unique case (REG_ADDR)
                REG_CTRL: begin
                    mode_cfg <= cppg_mode_e'(REG_WDATA[CTRL_MODE_BIT]);
                    res_sel <= REG_WDATA[CTRL_RES_LSB +: 2];
                    if (int'(REG_WDATA[CTRL_CAM_LSB +: 4]) <= CAMS) begin
                        cam_cfg <= REG_WDATA[CTRL_CAM_LSB +: 4];
                    end
                end
                REG_STROKE: stroke_cfg <= REG_WDATA;
                REG_START: start_cfg <= REG_WDATA[10:0];
                REG_NCRD: ncrd_cfg <= REG_WDATA[10:0];
                REG_CYCLEN: cyc_len <= REG_WDATA;
                REG_MADDR: begin
                    mem_prof <= REG_WDATA[MADDR_PROF_LSB +: 3];
                    mem_idx <= REG_WDATA[10:0];
                end
                REG_RATIO, REG_XVAL, REG_YVAL: mem_idx <= mem_idx + 11'h001;
                default: begin
                end
            endcase
        end
    end

    // Profile storage, index advances after each data write
    always_ff @(posedge CLK) begin
        if (REG_WR && REG_ADDR == REG_RATIO && int'(mem_prof) < CAMS && int'(mem_idx) < MAX_RES) begin
            ratio_mem[int'(mem_prof) * MAX_RES + int'(mem_idx)] <= sat(REG_WDATA, RATIO_FULL);
        end
        if (REG_WR && REG_ADDR == REG_XVAL && int'(mem_prof) < CAMS && int'(mem_idx) < CRD_N) begin
            x_mem[int'(mem_prof) * CRD_N + int'(mem_idx)] <= sat(REG_WDATA, CRD_LIMIT);
        end
        if (REG_WR && REG_ADDR == REG_YVAL && int'(mem_prof) < CAMS && int'(mem_idx) < CRD_N) begin
            y_mem[int'(mem_prof) * CRD_N + int'(mem_idx)] <= sat(REG_WDATA, CRD_LIMIT);
        end
    end

    // Mode and cam applied on engage; stroke applied only on a ratio-mode engage
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            act_mode <= CPPG_RATIO;
            act_cam <= 4'h0;
            act_stroke <= 32'sh0;
        end else if (rise) begin
            act_mode <= mode_cfg;
            act_cam <= cam_cfg;
            if (mode_cfg == CPPG_RATIO) begin
                act_stroke <= stroke_cfg;
            end
        end
    end

    // Ratio profile: step index, fraction and neighbouring points
    always_comb begin
        res = res_of(res_sel);
        scaled = {32'h0, CYCLE_POS} * 64'(res);
        if (cyc_len == 32'h0) begin
            step = 64'h0;
            frac = 64'h0;
        end else begin
            step = scaled / {32'h0, cyc_len};
            frac = scaled % {32'h0, cyc_len};
        end
        if (step >= 64'(res)) begin
            step = 64'(res - 1);
        end
        j = (int'(start_cfg) + int'(step[11:0])) & (res - 1);
        ra = ratio_at(act_cam, j, res);
        rb = ratio_at(act_cam, j + 1, res);
        r_last = ratio_at(act_cam, res, res);
    end

    // Coordinate profile: current segment and end segments
    always_comb begin
        p = signed'(CYCLE_POS);
        n = int'(ncrd_cfg);
        if (n < MIN_CRD) begin
            n = MIN_CRD;
        end
        if (n > CRD_N) begin
            n = CRD_N;
        end
        cbase = (act_cam == 4'h0) ? 0 : (int'(act_cam) - 1) * CRD_N;
        xa = x_mem[cbase + int'(seg)];
        xb = x_mem[cbase + int'(seg) + 1];
        ya = y_mem[cbase + int'(seg)];
        yb = y_mem[cbase + int'(seg) + 1];
        zero_if.a = y_mem[cbase];
        zero_if.b = y_mem[cbase + 1];
        zero_if.num = -x_mem[cbase];
        zero_if.den = x_mem[cbase + 1] - x_mem[cbase];
        full_if.a = y_mem[cbase + n - 2];
        full_if.b = y_mem[cbase + n - 1];
        full_if.num = signed'(cyc_len) - x_mem[cbase + n - 2];
        full_if.den = x_mem[cbase + n - 1] - x_mem[cbase + n - 2];
        if (act_cam == 4'h0) begin
            xa = 32'sh0;
            ya = 32'sh0;
            xb = signed'(cyc_len);
            yb = signed'(cyc_len);
            zero_if.a = 32'sh0;
            zero_if.b = 32'sh0;
            zero_if.num = 32'sh0;
            zero_if.den = 32'sh0;
            full_if.a = 32'sh0;
            full_if.b = signed'(cyc_len);
            full_if.num = 32'sh1;
            full_if.den = 32'sh1;
        end
        next_seg = seg;
        if (act_cam != 4'h0 && p >= xb && int'(seg) + 2 < n) begin
            next_seg = seg + 11'h001;
        end else if (act_cam != 4'h0 && p < xa && seg != 11'h000) begin
            next_seg = seg - 11'h001;
        end
        if (int'(seg) + 2 > n) begin
            next_seg = 11'(n - 2);
        end
    end

    // Interpolation, wrap detection and position update
    always_comb begin
        if (act_mode == CPPG_RATIO) begin
            seg_if.a = ra;
            seg_if.b = rb;
            seg_if.num = 32'(frac);
            seg_if.den = signed'(cyc_len);
            adv = 32'(64'(act_stroke) * 64'(r_last) / 64'(RATIO_FULL));
            wrap_fwd = (j_prev == res - 1) && (j == 0);
            wrap_bwd = (j_prev == 0) && (j == res - 1) && (res > 1);
        end else begin
            seg_if.a = ya;
            seg_if.b = yb;
            seg_if.num = p - xa;
            seg_if.den = xb - xa;
            adv = full_if.result - zero_if.result;
            wrap_fwd = (CYCLE_POS < p_prev) && ((p_prev - CYCLE_POS) > (cyc_len >> 1));
            wrap_bwd = (CYCLE_POS > p_prev) && ((CYCLE_POS - p_prev) > (cyc_len >> 1));
        end
        next_std = STD_POS;
        if (eng_s2 && wrap_fwd) begin
            next_std = STD_POS + adv;
        end else if (eng_s2 && wrap_bwd) begin
            next_std = STD_POS - adv;
        end
        if (act_mode == CPPG_RATIO) begin
            next_feed = next_std + 32'(64'(act_stroke) * 64'(seg_if.result) / 64'(RATIO_FULL));
        end else begin
            next_feed = next_std + seg_if.result;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            STD_POS <= 32'sh0;
            FEED_POS <= 32'sh0;
            CAM_ACTIVE <= 1'b0;
            j_prev <= 0;
            p_prev <= 32'h0;
            seg <= 11'h000;
        end else begin
            STD_POS <= next_std;
            if (eng_s2) begin
                FEED_POS <= next_feed;
            end
            CAM_ACTIVE <= eng_s2;
            j_prev <= j;
            p_prev <= CYCLE_POS;
            seg <= (act_mode == CPPG_COORD && wrap_fwd) ? 11'h000 : next_seg;
        end
    end

    // Read data stands one cycle after the read strobe
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            REG_RDATA <= 32'h0;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                REG_CTRL: REG_RDATA <= {24'h0, cam_cfg, 1'b0, res_sel, mode_cfg};
                REG_STROKE: REG_RDATA <= stroke_cfg;
                REG_START: REG_RDATA <= {21'h0, start_cfg};
                REG_NCRD: REG_RDATA <= {21'h0, ncrd_cfg};
                REG_CYCLEN: REG_RDATA <= cyc_len;
                REG_MADDR: REG_RDATA <= {17'h0, mem_prof, 1'b0, mem_idx};
                REG_STATUS: REG_RDATA <= {26'h0, CAM_ACTIVE, act_mode, act_cam};
                REG_FEED: REG_RDATA <= FEED_POS;
                REG_STDPOS: REG_RDATA <= STD_POS;
                default: REG_RDATA <= 32'h0;
            endcase
        end else begin
            REG_RDATA <= 32'h0;
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    property p_latch_stroke;
        rise && mode_cfg == CPPG_RATIO |=> act_stroke == $past(stroke_cfg);
    endproperty
    a_latch_stroke: assert property (p_latch_stroke) else $error("stroke not latched on engage");
    property p_hold_cam;
        !rise |=> $stable(act_cam) && $stable(act_stroke);
    endproperty
    a_hold_cam: assert property (p_hold_cam) else $error("settings changed without engage");
    property p_coord_stroke;
        rise && mode_cfg == CPPG_COORD |=> $stable(act_stroke) && act_cam == $past(cam_cfg);
    endproperty
    a_coord_stroke: assert property (p_coord_stroke) else $error("coordinate engage latch wrong");
    property p_std_only_wrap;
        !(eng_s2 && (wrap_fwd || wrap_bwd)) |=> $stable(STD_POS);
    endproperty
    a_std_only_wrap: assert property (p_std_only_wrap) else $error("standard position moved off wrap");
    property p_ratio_adv;
        eng_s2 && act_mode == CPPG_RATIO && wrap_fwd
            |=> STD_POS == $past(STD_POS) + 32'(64'($past(act_stroke)) * 64'($past(r_last)) / 64'(RATIO_FULL));
    endproperty
    a_ratio_adv: assert property (p_ratio_adv) else $error("ratio advance wrong");
    property p_coord_adv;
        eng_s2 && act_mode == CPPG_COORD && wrap_fwd
            |=> STD_POS - $past(STD_POS) == $past(full_if.result) - $past(zero_if.result);
    endproperty
    a_coord_adv: assert property (p_coord_adv) else $error("coordinate advance wrong");
    property p_start_point;
        act_mode == CPPG_RATIO && CYCLE_POS == 32'h0 |-> j == (int'(start_cfg) & (res - 1));
    endproperty
    a_start_point: assert property (p_start_point) else $error("start point not at position zero");
    property p_linear_last;
        act_cam == 4'h0 |-> r_last == RATIO_FULL;
    endproperty
    a_linear_last: assert property (p_linear_last) else $error("linear cam not full at last point");
    property p_feed_origin;
        eng_s2 && act_mode == CPPG_RATIO && CYCLE_POS == 32'h0 && (int'(start_cfg) & (res - 1)) == 0
            |=> FEED_POS == STD_POS;
    endproperty
    a_feed_origin: assert property (p_feed_origin) else $error("feed off standard at point zero");
endmodule
`default_nettype wire

/* File: shared/cppg_interp_if.sv */
// Purpose: Carries one interpolation request and its result
// Assumes: Purely combinational use
// Notes: result = a + (b - a) * num / den
`timescale 1ns/100ps
`default_nettype none
interface cppg_interp_if;
    logic signed [31:0] a;
    logic signed [31:0] b;
    logic signed [31:0] num;
    logic signed [31:0] den;
    logic signed [31:0] result;
    modport calc (input a, input b, input num, input den, output result);
    modport user (output a, output b, output num, output den, input result);
endinterface
`default_nettype wire

/* File: shared/cppg_pkg.sv */
// Purpose: Shared constants and types of the cam profile position generator
// Assumes: Values in thousandths; one register word per 32-bit offset
// Notes: Ratio full scale is 100.000 percent
package cppg_pkg;
    localparam int NUM_CAMS = 8;
    localparam int MAX_RES = 2048;
    localparam int RES_BASE = 256;
    localparam int MIN_CRD = 2;
    localparam int MAX_CRD = 1024;
    localparam logic signed [31:0] RATIO_FULL = 32'sh000186a0;
    localparam logic signed [31:0] CRD_LIMIT = 32'sh000f423f;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STROKE = 8'h04;
    localparam logic [7:0] REG_START = 8'h08;
    localparam logic [7:0] REG_NCRD = 8'h0c;
    localparam logic [7:0] REG_CYCLEN = 8'h10;
    localparam logic [7:0] REG_MADDR = 8'h14;
    localparam logic [7:0] REG_RATIO = 8'h18;
    localparam logic [7:0] REG_XVAL = 8'h1c;
    localparam logic [7:0] REG_YVAL = 8'h20;
    localparam logic [7:0] REG_STATUS = 8'h24;
    localparam logic [7:0] REG_FEED = 8'h28;
    localparam logic [7:0] REG_STDPOS = 8'h2c;
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_RES_LSB = 1;
    localparam int CTRL_CAM_LSB = 4;
    localparam int MADDR_PROF_LSB = 12;
    localparam logic [31:0] CYCLEN_RST = 32'h00002710;
    localparam logic [10:0] NCRD_RST = 11'h002;
    localparam logic [10:0] START_RST = 11'h000;
    typedef enum logic {
        CPPG_RATIO = 1'b0,
        CPPG_COORD = 1'b1
    } cppg_mode_e;
endpackage

/* File: verification/cppg_host_model.sv */
// Purpose: Host side model driving the engage pin and the cam cycle position
// Assumes: Single clock domain shared with the block
// Notes: A zero slew makes position jumps, otherwise it moves in fixed steps
`timescale 1ns/100ps
`default_nettype none
module cppg_host_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic engage_req,
    input wire logic [31:0] target_pos,
    input wire logic [31:0] slew,
    output logic engage,
    output logic [31:0] cycle_pos
);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            engage <= 1'b0;
        end else begin
            engage <= engage_req;
        end
    end

    // Slow moves never cross the cycle end, so a wrap is always a jump
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cycle_pos <= 32'h0;
        end else if (slew == 32'h0 || target_pos - cycle_pos <= slew || cycle_pos - target_pos <= slew) begin
            cycle_pos <= target_pos;
        end else if (cycle_pos < target_pos) begin
            cycle_pos <= cycle_pos + slew;
        end else begin
            cycle_pos <= cycle_pos - slew;
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the cam profile position generator
// Assumes: Register port with read data one cycle after the strobe
// Notes: Linear cam, stored ratio profile and coordinate profile are covered
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import cppg_pkg::*;
    logic clk;
    logic reset;
    logic engage_req;
    logic cam_engage_command;
    logic reg_wr;
    logic reg_rd;
    logic cam_active;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic [31:0] target_pos;
    logic [31:0] slew;
    logic [31:0] cycle_pos;
    logic signed [31:0] feed_pos;
    logic signed [31:0] std_pos;
    int mismatches = 0;
    int compares = 0;

    cppg_host_model host (.clk(clk), .reset(reset), .engage_req(engage_req), .target_pos(target_pos),
        .slew(slew), .engage(cam_engage_command), .cycle_pos(cycle_pos));

    cppg_top DUT (.CLK(clk), .RESET(reset), .CAM_ENGAGE_COMMAND(cam_engage_command), .CYCLE_POS(cycle_pos),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .FEED_POS(feed_pos), .STD_POS(std_pos), .CAM_ACTIVE(cam_active));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic reset_dut;
        @(posedge clk);
        reset <= 1'b1;
        engage_req <= 1'b0;
        target_pos <= 32'h0;
        slew <= 32'h0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask

    // Waits a bounded time for the block to report the new engage level
    task automatic engage(input logic lvl);
        int i;
        @(posedge clk);
        engage_req <= lvl;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (cam_active === lvl) begin
                break;
            end
        end
        if (i == 20) begin
            mismatches++;
            $display("[FAIL] t=%0t engage level not reached", $time);
            print_verdict();
        end
    endtask

    // Long enough for a slow host move and for the segment tracker to settle
    task automatic move(input logic [31:0] p);
        @(posedge clk);
        target_pos <= p;
        repeat (80) @(posedge clk);
        #1;
    endtask

    task automatic pos_check(input logic [31:0] p, input logic [31:0] exp);
        move(p);
        check(feed_pos, exp);
    endtask

    initial begin
        reset = 1'b1;
        engage_req = 1'b0;
        target_pos = 32'h0;
        slew = 32'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reset_dut();
        rd(REG_CTRL, 32'h0);
        rd(REG_START, 32'h0);
        rd(REG_NCRD, 32'h2);
        rd(REG_CYCLEN, CYCLEN_RST);
        rd(8'h30, 32'h0);
        // Built-in linear cam, 256 steps of ten position units
        wr(REG_CYCLEN, 32'd2560);
        wr(REG_STROKE, 32'd1000);
        move(32'd640);
        engage(1'b1);
        rd(REG_STATUS, 32'h20);
        pos_check(32'd640, 32'd250);
        wr(REG_STROKE, 32'd2000);
        pos_check(32'd1280, 32'd500);
        check(std_pos, 32'h0);
        engage(1'b0);
        engage(1'b1);
        pos_check(32'd1280, 32'd1000);
        move(32'd2550);
        pos_check(32'd0, 32'd2000);
        check(std_pos, 32'd2000);
        pos_check(32'd640, 32'd2500);
        wr(REG_CTRL, 32'h06);
        pos_check(32'd645, 32'd2503);
        // Stored ratio profile on cam one, 512 steps, last point over range
        reset_dut();
        wr(REG_MADDR, 32'h0);
        for (int k = 0; k < 512; k++) begin
            wr(REG_RATIO, (k == 511) ? 32'd200000 : 32'((k + 1) * 100));
        end
        wr(REG_CTRL, 32'h12);
        wr(REG_CYCLEN, 32'd5120);
        wr(REG_STROKE, 32'd10000);
        wr(REG_START, 32'd256);
        engage(1'b1);
        rd(REG_STATUS, 32'h21);
        pos_check(32'd0, 32'd2560);
        pos_check(32'd1000, 32'd3560);
        wr(REG_START, 32'd0);
        pos_check(32'd1000, 32'd1000);
        wr(REG_CTRL, 32'h02);
        rd(REG_STATUS, 32'h21);
        slew <= 32'd64;
        pos_check(32'd5115, 32'd7555);
        // Last point made zero: a wrap must leave the standard position in place
        wr(REG_MADDR, 32'd511);
        wr(REG_RATIO, 32'h0);
        slew <= 32'h0;
        pos_check(32'd0, 32'h0);
        check(std_pos, 32'h0);
        // Coordinate profile on cam one with three pairs
        reset_dut();
        wr(REG_MADDR, 32'h0);
        wr(REG_XVAL, 32'd100);
        wr(REG_XVAL, 32'd200);
        wr(REG_XVAL, 32'd300);
        wr(REG_MADDR, 32'h0);
        wr(REG_YVAL, 32'd0);
        wr(REG_YVAL, 32'd1000);
        wr(REG_YVAL, 32'd500);
        wr(REG_CTRL, 32'h11);
        wr(REG_CYCLEN, 32'd1000);
        wr(REG_NCRD, 32'd3);
        wr(REG_START, 32'd5);
        move(32'd150);
        engage(1'b1);
        rd(REG_STATUS, 32'h31);
        pos_check(32'd150, 32'd500);
        pos_check(32'd50, -32'sd500);
        // Slow move, so the block does not take it for a backward wrap
        slew <= 32'd64;
        pos_check(32'd900, -32'sd2500);
        slew <= 32'h0;
        pos_check(32'd0, -32'sd3000);
        check(std_pos, -32'sd2000);
        print_verdict();
    end
endmodule
`default_nettype wire
